/* hdl/config_readback_pin_control.sv */
// The address map and the AHB-Lite slave port are this design's own decisions.
`include "cfg_params.svh"
module config_readback_pin_control
    import cfg_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic                       irq,
    // configuration pins
    input  wire logic                  config_restart_n,
    input  wire logic                  rd_cfg_n,
    input  wire logic                  init_i,
    output logic                       init_o,
    output logic                       init_oe_n,
    input  wire logic [3:0]            mode_i,
    output logic                       mode_pullup_en,
    output logic                       mode_user_io,
    output logic                       pll_pullup_en,
    output logic [`PLL_PINS-1:0]       pll_user_io,
    output logic                       tristate_all,
    output logic                       scan_reset,
    input  wire logic                  scan_active,
    input  wire logic                  scan_tdo,
    output logic                       rd_data,
    input  wire logic                  init_error,
    output logic                       cfg_err_irq_n,
    input  wire logic [31:0]           frame_word,
    output logic [7:0]                 frame_addr,
    output logic                       cfg_done
);
    // sequencer and software-visible state
    cfg_state_t         state_r;
    logic [15:0]        clr_cnt_r;
    logic [2:0]         ctrl_r;
    logic [`EV_W-1:0]   status_r;
    logic [`EV_W-1:0]   mask_r;
    logic [`PLL_PINS-1:0] pll_used_r;
    logic [3:0]         mode_r;
    logic               err_r;
    // bus write capture and event vectors
    logic               wr_pend_r;
    logic [7:0]         wr_addr_r;
    logic               finish_req;
    logic [`EV_W-1:0]   ev_set;
    logic [`EV_W-1:0]   ev_clr;
    // synchronised pin views and edges
    logic               restart_lvl;
    logic               restart_fall;
    logic               rdcfg_lvl;
    logic               rdcfg_fall;
    logic               init_rise;
    logic               addr_take;
    logic [31:0]        rd_mux;

    readback_if rb ();

    // ==========================================
    // input synchronisers
    pin_sync #(.RST_VAL(1'b1)) u_sync_restart (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_i   (config_restart_n),
        .level_o (restart_lvl),
        .fall_o  (restart_fall),
        .rise_o  ()
    );
    pin_sync #(.RST_VAL(1'b1)) u_sync_rdcfg (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_i   (rd_cfg_n),
        .level_o (rdcfg_lvl),
        .fall_o  (rdcfg_fall),
        .rise_o  ()
    );
    pin_sync #(.RST_VAL(1'b0)) u_sync_init (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin_i   (init_i),
        .level_o (),
        .fall_o  (),
        .rise_o  (init_rise)
    );

    // ==========================================
    // readback engine
    assign rb.frame_word = frame_word;
    // each fall restarts readback when enabled in user mode
    assign rb.start = rdcfg_fall & ctrl_r[`CTRL_RB_EN] & (state_r == ST_USER);

    readback_engine u_rb (
        .hclk    (hclk),
        .hresetn (hresetn),
        .rb      (rb)
    );

    // ==========================================
    // ahb-lite slave, zero wait states
    assign addr_take = hsel & htrans[1] & hready;
    assign finish_req = wr_pend_r & (wr_addr_r == `OFS_CTRL) & hwdata[`CTRL_FINISH];

    // write address captured in the address phase, data used next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_take & hwrite;
            if (addr_take) begin
                wr_addr_r <= haddr[7:0];
            end
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            `OFS_CTRL:     rd_mux[2:0] = ctrl_r;
            `OFS_STATUS:   rd_mux[`EV_W-1:0] = status_r;
            `OFS_MASK:     rd_mux[`EV_W-1:0] = mask_r;
            `OFS_STATE:    rd_mux[9:0] = {rb.busy, err_r, mode_r, state_r};
            `OFS_PLL_USED: rd_mux[`PLL_PINS-1:0] = pll_used_r;
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    // read data registered at the address phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // never stalls and never errors
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ==========================================
    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r     <= `CTRL_RST;
            mask_r     <= `MASK_RST;
            pll_used_r <= `PLL_USED_RST;
        end else if (wr_pend_r) begin
            if (wr_addr_r == `OFS_CTRL) begin
                ctrl_r <= hwdata[2:0];
            end
            if (wr_addr_r == `OFS_MASK) begin
                mask_r <= hwdata[`EV_W-1:0];
            end
            if (wr_addr_r == `OFS_PLL_USED) begin
                pll_used_r <= hwdata[`PLL_PINS-1:0];
            end
        end
    end

    // ==========================================
    // configuration sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r   <= ST_CLEAR;
            clr_cnt_r <= 16'(`INIT_CLEAR_CYC);
        end else if (!restart_lvl) begin
            state_r   <= ST_CLEAR;
            clr_cnt_r <= 16'(`INIT_CLEAR_CYC);
        end else begin
            unique case (state_r)
                ST_CLEAR: begin
                    if (clr_cnt_r == 16'h0001) begin
                        state_r <= ST_WAIT_INIT;
                    end else begin
                        clr_cnt_r <= clr_cnt_r - 16'h0001;
                    end
                end
                ST_WAIT_INIT: begin
                    if (init_rise) begin
                        state_r <= ST_CONFIG;
                    end
                end
                ST_CONFIG: begin
                    if (finish_req) begin
                        state_r <= ST_USER;
                    end
                end
                ST_USER: begin
                    state_r <= ST_USER;
                end
                default: begin
                    state_r <= ST_CLEAR;
                end
            endcase
        end
    end

    // mode pins caught on the rising edge of init only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r <= 4'h0;
        end else if (state_r == ST_WAIT_INIT && init_rise && restart_lvl) begin
            mode_r <= mode_i;
        end
    end

    // init error latch, cleared only by a restart
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_r <= 1'b0;
        end else if (!restart_lvl) begin
            err_r <= 1'b0;
        end else if (state_r == ST_CONFIG && init_error) begin
            err_r <= 1'b1;
        end
    end

    // ==========================================
    // sticky events, write one to clear; a set wins over a clear
    assign ev_set[`EV_ERR]      = state_r == ST_CONFIG && init_error && restart_lvl;
    assign ev_set[`EV_RB_DONE]  = rb.done;
    assign ev_set[`EV_RESTART]  = restart_fall;
    assign ev_set[`EV_CFG_DONE] = state_r == ST_CONFIG && finish_req && restart_lvl;
    assign ev_clr = (wr_pend_r && wr_addr_r == `OFS_STATUS) ? hwdata[`EV_W-1:0] : 4'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r <= 4'h0;
            irq      <= 1'b0;
        end else begin
            status_r <= (status_r & ~ev_clr) | ev_set;
            irq      <= |(((status_r & ~ev_clr) | ev_set) & mask_r);
        end
    end

    // ==========================================
    // pin drivers, all registered
    // init is only ever pulled low; the board pull-up raises it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_o    <= 1'b0;
            init_oe_n <= 1'b0;
        end else begin
            init_o    <= 1'b0;
            init_oe_n <= ~(state_r == ST_CLEAR);
        end
    end

    // scan logic held in reset while the restart input is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scan_reset <= 1'b1;
        end else begin
            scan_reset <= ~restart_lvl;
        end
    end

    // tristate-all always honoured while configuring, by option afterwards
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tristate_all <= 1'b1;
        end else if (state_r == ST_USER) begin
            tristate_all <= ctrl_r[`CTRL_TS_AFTER] & ~rdcfg_lvl;
        end else begin
            tristate_all <= ~rdcfg_lvl;
        end
    end

    // mode straps pulled up until configuration ends, then user i/o
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_pullup_en <= 1'b1;
            mode_user_io   <= 1'b0;
        end else begin
            mode_pullup_en <= state_r != ST_USER;
            mode_user_io   <= state_r == ST_USER;
        end
    end

    // only pll pins that no pll claims become user i/o
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pll_pullup_en <= 1'b1;
            pll_user_io   <= '0;
        end else begin
            pll_pullup_en <= state_r != ST_USER;
            pll_user_io   <= (state_r == ST_USER) ? ~pll_used_r : '0;
        end
    end

    // done flag lags the state by one clock, like every other pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_done <= 1'b0;
        end else begin
            cfg_done <= state_r == ST_USER;
        end
    end

    // shared data pin; scan data delayed one clock through the register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data <= 1'b0;
        end else begin
            rd_data <= scan_active ? scan_tdo : rb.bit_out;
        end
    end

    // frame address a clock behind the engine, which waits for it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_addr <= 8'h00;
        end else begin
            frame_addr <= rb.frame_addr;
        end
    end

    // shared request pin: error latch while configuring, host irq after
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_err_irq_n <= 1'b1;
        end else if (state_r == ST_USER && ctrl_r[`CTRL_HOST_EN]) begin
            cfg_err_irq_n <= ~irq;
        end else begin
            cfg_err_irq_n <= ~err_r;
        end
    end
endmodule // config_readback_pin_control

/* hdl/cfg_params.svh */
`ifndef CFG_PARAMS_SVH
`define CFG_PARAMS_SVH
// Behaviour
// - restart input low restarts configuration, resets scan
// - read-config low during configuration tristates all I/O
// - option keeps tristate-all function after configuration
// - enabled readback starts at frame 0 on fall
// - readback data shares pin with scan data out
// - init errors pull error output low during configuration
// - error pin doubles as host port interrupt
// - mode pins latched on init rising edge
// - mode pins become user I/O after configuration
// - PLL pins pulled-up high-Z, then user I/O
// - init held low during clearing, released before config

// ==========================================
// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_MASK      8'h08
`define OFS_STATE     8'h0c
`define OFS_PLL_USED  8'h10

// ==========================================
// control and status bit positions
`define CTRL_TS_AFTER   0
`define CTRL_RB_EN      1
`define CTRL_HOST_EN    2
`define CTRL_FINISH     3
`define EV_ERR          0
`define EV_RB_DONE      1
`define EV_RESTART      2
`define EV_CFG_DONE     3
`define EV_W            4

// ==========================================
// reset values
`define CTRL_RST      3'h0
`define MASK_RST      4'h0
`define PLL_USED_RST  16'h0000

// ==========================================
// timing and sizes
`define CLK_MHZ         10
`define INIT_CLEAR_NS   1000
`define INIT_CLEAR_CYC  ((`INIT_CLEAR_NS * `CLK_MHZ + 999) / 1000)
`define RB_FRAMES       8'h10
`define PLL_PINS        16
`endif

/* hdl/cfg_pkg.sv */
package cfg_pkg;
    // one-hot configuration sequencer states
    typedef enum logic [3:0] {
        ST_CLEAR     = 4'h1,
        ST_WAIT_INIT = 4'h2,
        ST_CONFIG    = 4'h4,
        ST_USER      = 4'h8
    } cfg_state_t;
endpackage

/* hdl/readback_if.sv */
interface readback_if;
    logic        start;
    logic        busy;
    logic        done;
    logic        bit_out;
    logic [7:0]  frame_addr;
    logic [31:0] frame_word;

    modport ctl (output start, output frame_word, input busy, input done, input bit_out, input frame_addr);
    modport eng (input start, input frame_word, output busy, output done, output bit_out, output frame_addr);
endinterface

/* hdl/pin_sync.sv */
module pin_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      fall_o,
    output logic      rise_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // ==========================================
    // two-stage synchroniser, third stage only for edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign level_o = s2_r;
    assign fall_o  = s3_r & ~s2_r; // one pulse per transition
    assign rise_o  = ~s3_r & s2_r;
endmodule // pin_sync

/* hdl/readback_engine.sv */
`include "cfg_params.svh"
module readback_engine (
    input  wire logic hclk,
    input  wire logic hresetn,
    readback_if.eng   rb
);
    logic [4:0]  bit_cnt_r;
    logic [31:0] shift_r;
    logic        fetch_r;
    logic        load_r;

    // ==========================================
    // frame walk from frame 0; fetch then load, as the pin address lags a clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rb.busy       <= 1'b0;
            rb.done       <= 1'b0;
            rb.frame_addr <= 8'h00;
            bit_cnt_r     <= 5'h00;
            fetch_r       <= 1'b0;
            load_r        <= 1'b0;
        end else begin
            rb.done <= 1'b0;
            fetch_r <= 1'b0;
            load_r  <= fetch_r;
            if (rb.start) begin
                rb.busy       <= 1'b1;
                rb.frame_addr <= 8'h00;
                bit_cnt_r     <= 5'h00;
                fetch_r       <= 1'b1;
                load_r        <= 1'b0;
            end else if (rb.busy && !fetch_r && !load_r) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
                if (bit_cnt_r == 5'h1f) begin
                    if (rb.frame_addr == `RB_FRAMES - 8'h01) begin
                        rb.busy <= 1'b0;
                        rb.done <= 1'b1;
                    end else begin
                        rb.frame_addr <= rb.frame_addr + 8'h01;
                        fetch_r       <= 1'b1;
                    end
                end
            end
        end
    end

    // ==========================================
    // word shifter, msb first; word taken two cycles after the address moves
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_r <= 32'h0000_0000;
        end else if (load_r) begin
            shift_r <= rb.frame_word;
        end else if (rb.busy) begin
            shift_r <= {shift_r[30:0], 1'b0};
        end
    end

    assign rb.bit_out = rb.busy & ~fetch_r & ~load_r & shift_r[31];
endmodule // readback_engine

/* tb/cfg_board_host.sv */
// ==========================================
// board side: init wire, mode straps, frame store
module cfg_board_host (
    input  wire logic        init_oe_n,
    input  wire logic        init_o,
    input  wire logic        host_init_low,
    input  wire logic [3:0]  mode_val,
    input  wire logic [7:0]  frame_addr,
    output logic             init_i,
    output logic [3:0]       mode_i,
    output logic [31:0]      frame_word
);
    timeunit 1ns;
    timeprecision 1ns;
    // open-drain init with pull-up: low if either side pulls it
    assign init_i = !((!init_oe_n && !init_o) || host_init_low);
    // host holds the straps; pull-ups only matter when undriven
    assign mode_i = mode_val;
    // per-frame pattern, distinct per address so frames cannot alias
    assign frame_word = {frame_addr, 8'ha5, ~frame_addr, 8'h3c};
endmodule // cfg_board_host

/* tb/cfg_pins_props.sv */
// ==========================================
// pin behaviour properties
module cfg_pins_props (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        config_restart_n,
    input wire logic        rd_cfg_n,
    input wire logic        init_o,
    input wire logic        init_oe_n,
    input wire logic        mode_pullup_en,
    input wire logic        mode_user_io,
    input wire logic        pll_pullup_en,
    input wire logic [15:0] pll_user_io,
    input wire logic        tristate_all,
    input wire logic        scan_reset,
    input wire logic        scan_active,
    input wire logic        scan_tdo,
    input wire logic        rd_data,
    input wire logic        cfg_err_irq_n,
    input wire logic [7:0]  frame_addr,
    input wire logic        cfg_done
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // margins follow the two-flop sync plus one output register
    a_restart_scan_rst: assert property (!config_restart_n [*3] |=> scan_reset)
        else $error("scan reset missing");
    a_restart_drops_cfg: assert property (!config_restart_n [*4] |=> !cfg_done && !init_oe_n)
        else $error("restart ignored");
    a_ts_cfg_low: assert property ((!cfg_done && !rd_cfg_n) [*4] ##1 !cfg_done |-> tristate_all)
        else $error("tristate missing");
    a_ts_release: assert property (rd_cfg_n [*4] |=> !tristate_all)
        else $error("tristate stuck");
    a_scan_tdo_path: assert property (scan_active |=> rd_data == $past(scan_tdo))
        else $error("tdo not passed");
    a_err_pin_sticky: assert property ((config_restart_n [*4] ##0 (!cfg_done && !cfg_err_irq_n))
        |=> cfg_done || !cfg_err_irq_n)
        else $error("error pin dropped");
    a_mode_pin_role: assert property (mode_user_io == cfg_done && mode_pullup_en == !cfg_done)
        else $error("mode pin role wrong");
    a_pll_cfg_hold: assert property (!cfg_done |-> pll_pullup_en && pll_user_io == 16'h0000)
        else $error("pll pins released early");
    a_init_clear: assert property ($fell(init_oe_n) |-> (!init_o && !cfg_done && !init_oe_n) [*8])
        else $error("init clear too short");
    a_frame_step: assert property (cfg_done && $changed(frame_addr)
        |-> frame_addr == 8'h00 || frame_addr == $past(frame_addr) + 8'h01)
        else $error("frame address skipped");
endmodule // cfg_pins_props

bind config_readback_pin_control cfg_pins_props u_cfg_pins_props (.hclk, .hresetn, .config_restart_n, .rd_cfg_n,
    .init_o, .init_oe_n, .mode_pullup_en, .mode_user_io, .pll_pullup_en, .pll_user_io, .tristate_all, .scan_reset,
    .scan_active, .scan_tdo, .rd_data, .cfg_err_irq_n, .frame_addr, .cfg_done);

/* tb/config_readback_pin_control_test.sv */
`include "cfg_params.svh"
module config_readback_pin_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, config_restart_n = 1, rd_cfg_n = 1;
    logic        host_init_low = 1, scan_active = 0, scan_tdo = 0, init_error = 0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, frame_word;
    logic [3:0]  mode_val = 4'hf, mode_i;
    logic        hreadyout, hresp, irq, init_i, init_o, init_oe_n, mode_pullup_en, mode_user_io;
    logic        pll_pullup_en, tristate_all, scan_reset, rd_data, cfg_err_irq_n, cfg_done;
    logic [15:0] pll_user_io;
    logic [7:0]  frame_addr;
    int          n_fail = 0, cmp_count = 0, cycles = 0;

    config_readback_pin_control u_config_readback_pin_control (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .config_restart_n,
        .rd_cfg_n, .init_i, .init_o, .init_oe_n, .mode_i, .mode_pullup_en, .mode_user_io, .pll_pullup_en,
        .pll_user_io, .tristate_all, .scan_reset, .scan_active, .scan_tdo, .rd_data, .init_error, .cfg_err_irq_n,
        .frame_word, .frame_addr, .cfg_done);
    cfg_board_host u_cfg_board_host (.init_oe_n, .init_o, .host_init_low, .mode_val, .frame_addr, .init_i,
        .mode_i, .frame_word);

    // ==========================================
    // clock and hang guard
    always #50 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one single ahb-lite transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(a, 1'b1, d, x);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        ahb(a, 1'b0, 32'h0, x);
        chk(nm, exp, x);
    endtask
    function automatic logic [31:0] word_of(input logic [7:0] f);
        return {f, 8'ha5, ~f, 8'h3c};
    endfunction

    // ==========================================
    // main sequence
    initial begin
        logic [31:0] x;
        logic [3:0]  m;
        logic [15:0] pu;
        logic        t;
        logic [0:149] bits;
        int          pos;
        x = $urandom(32'h1125);
        repeat (12) @(posedge hclk);
        chk("reset pins", 32'hc, {tristate_all, cfg_err_irq_n, init_oe_n, cfg_done});
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("state clear", `OFS_STATE, 32'h1);
        for (int i = 0; i < 6; i++) if (i != 3) rd_chk("reset reg", 8'(4 * i), 32'h0);
        repeat (12) @(posedge hclk);
        chk("init released", 32'h1, {31'h0, init_oe_n});
        rd_chk("state wait", `OFS_STATE, 32'h2);
        m = 4'($urandom);
        mode_val <= m;
        host_init_low <= 1'b0;
        repeat (6) @(posedge hclk);
        mode_val <= ~m;
        rd_cfg_n <= 1'b0;
        repeat (5) @(posedge hclk);
        chk("ts in config", 32'h1, {31'h0, tristate_all});
        rd_chk("mode latch", `OFS_STATE, {24'h0, m, 4'h4});
        rd_cfg_n <= 1'b1;
        init_error <= 1'b1;
        @(posedge hclk);
        init_error <= 1'b0;
        repeat (4) @(posedge hclk);
        chk("err pin", 32'h0, {31'h0, cfg_err_irq_n});
        rd_chk("err event", `OFS_STATUS, 32'h1);
        wr(`OFS_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq set", 32'h1, {31'h0, irq});
        wr(`OFS_STATUS, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq clear", 32'h0, {30'h0, irq, cfg_err_irq_n});
        pu = 16'($urandom);
        wr(`OFS_PLL_USED, {16'h0, pu});
        wr(`OFS_CTRL, 32'he);
        repeat (3) @(posedge hclk);
        chk("user pll", {16'h0, ~pu}, {16'h0, pll_user_io});
        chk("user pins", 32'h7, {29'h0, cfg_done, mode_user_io, cfg_err_irq_n});
        wr(`OFS_MASK, 32'h8);
        repeat (3) @(posedge hclk);
        chk("host irq", 32'h2, {30'h0, irq, cfg_err_irq_n});
        wr(`OFS_STATUS, 32'hf);
        wr(`OFS_MASK, 32'h0);
        scan_active <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            t = 1'($urandom);
            scan_tdo <= t;
            @(posedge hclk);
            @(posedge hclk);
            chk("tdo", {31'h0, t}, {31'h0, rd_data});
        end
        scan_active <= 1'b0;
        rd_cfg_n <= 1'b0;
        for (int i = 0; i < 150; i++) begin
            @(posedge hclk);
            bits[i] = rd_data;
        end
        pos = -1;
        for (int i = 0; i < 85; i++) if (pos < 0 && bits[i +: 32] === word_of(8'h00)) pos = i;
        chk("frame0 found", 32'h1, {31'h0, pos >= 0});
        if (pos >= 0) chk("frame1", word_of(8'h01), bits[pos + 34 +: 32]);
        chk("no ts", 32'h0, {31'h0, tristate_all});
        rd_cfg_n <= 1'b1;
        repeat (500) @(posedge hclk);
        rd_chk("rb done", `OFS_STATUS, 32'h2);
        wr(`OFS_CTRL, 32'h1);
        rd_cfg_n <= 1'b0;
        repeat (5) @(posedge hclk);
        chk("ts after", 32'h1, {31'h0, tristate_all});
        rd_chk("rb refused", `OFS_STATE, {23'h0, 1'b1, m, 4'h8});
        rd_cfg_n <= 1'b1;
        config_restart_n <= 1'b0;
        repeat (5) @(posedge hclk);
        chk("restart pins", 32'h2, {30'h0, scan_reset, cfg_done});
        config_restart_n <= 1'b1;
        ahb(`OFS_STATE, 1'b0, 32'h0, x);
        chk("restart state", 32'h1, x & 32'h10f);
        rd_chk("ctrl kept", `OFS_CTRL, 32'h1);
        rd_chk("restart event", `OFS_STATUS, 32'h6);
        give_verdict();
    end
endmodule // config_readback_pin_control_test
